// ===== rtl/oag_ea_adder.sv
// Purpose: 16-bit base plus zero-extended byte offset.
// Assumes: Offset is unsigned.
// Notes: Carry out of bit 15 is dropped on purpose.
`timescale 1ns/1ps
module oag_ea_adder (
    input wire logic [15:0] base, // Base pointer value
    input wire logic [7:0] offset, // Unsigned displacement
    output logic [15:0] sum // Wrapped sum
);
    import oag_pkg::*;

    logic [16:0] wide;

    // Wide sum, then truncate to discard the carry
    always_comb begin
        wide = {1'b0, base} + {9'h000, offset};
        sum = wide[15:0];
    end
endmodule : oag_ea_adder

// ===== rtl/oag_operand_address_generator.sv
// Purpose: Turns a decoded operand field into a register pick or an effective address.
// Assumes: Register file contents are visible as the banked pairs and bytes below.
// Notes: One clock of latency from request to result.
//        Faults are flags only; the core decides whether to trap the access.
// Operation
// - Multiply takes accumulator, product into accumulator pair
// - Word divide uses accumulator pair both ways
// - Decimal adjusts correct the accumulator
// - Digit rotates hold digits in accumulator
// - Bank flags plus 3-bit code pick register
// - Function names map to absolute registers, pairs
// - Direct mode uses 16-bit immediate address
// - Short direct reaches FE20H to FF1FH only
// - Bit 8 set only for immediates below 20H
// - RAM FE20H-FEFFH, SFRs FF00H-FF1FH in window
// - SFR mode selects FF00H-FFCFH or FFE0H-FFFFH
// - Low SFRs also reachable by short direct
// - Indirect uses banked second or base pair
// - Based adds zero-extended byte to base pair
// - Based indexed adds banked B or C
// - Stack mode automatic for push, pop, call, interrupts
// - Stack reaches internal high-speed RAM only
`timescale 1ns/1ps
module oag_operand_address_generator #(
    parameter logic [15:0] STACK_LO = oag_pkg::OAG_STACK_LO_DEF, // Stack RAM low bound
    parameter logic [15:0] STACK_HI = oag_pkg::OAG_STACK_HI_DEF // Stack RAM high bound
) (
    input wire logic clk, // Core clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic opValid, // Operand request this cycle
    input wire oag_pkg::oag_mode_e opMode, // Addressing mode
    input wire oag_pkg::oag_implied_e impliedOp, // Implied instruction kind
    input wire logic [2:0] regCode, // Register or pair code
    input wire logic wordOp, // Word-sized operand
    input wire logic indexUsesB, // Based indexed picks B, else C
    input wire logic pointerIsBase, // Indirect uses base pair, else second
    input wire logic [15:0] imm16, // 16-bit immediate
    input wire logic [7:0] imm8, // 8-bit immediate
    input wire logic bank_select_bit0, // Bank select flag 0
    input wire logic bank_select_bit1, // Bank select flag 1
    input wire logic [15:0] basePointerPair, // Banked base pair contents
    input wire logic [15:0] secondPointerPair, // Banked second pair contents
    input wire logic [7:0] indexB, // Banked B register
    input wire logic [7:0] indexC, // Banked C register
    input wire logic [15:0] stack_pointer, // Stack pointer contents
    output logic resValid, // Result valid pulse
    output logic isRegister, // Operand is a register
    output logic [4:0] srcIndex, // Absolute source byte index
    output logic [4:0] dstIndex, // Absolute destination byte index
    output logic dstWord, // Destination is a pair
    output logic [15:0] effAddr, // Memory effective address
    output logic inShortRam, // Address in short window RAM
    output logic inShortSfr, // Address in short window SFRs
    output logic addrFault // Misaligned short or SFR word, SFR gap, stack outside RAM or unassigned implied code
);
    import oag_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Combinational helpers

    logic [1:0] bankSel;
    logic [4:0] regIndex;
    logic [15:0] basedSum;
    logic [15:0] indexedSum;
    logic [7:0] indexByte;

    assign bankSel = {bank_select_bit1, bank_select_bit0};
    assign indexByte = indexUsesB ? indexB : indexC;

    oag_reg_select regSel (
        .bankSel(bankSel),
        .regCode(regCode),
        .wordOp(wordOp),
        .byteIndex(regIndex),
        .absReg()
    );

    oag_ea_adder basedAdd (
        .base(basePointerPair),
        .offset(imm8),
        .sum(basedSum)
    );

    oag_ea_adder indexedAdd (
        .base(basePointerPair),
        .offset(indexByte),
        .sum(indexedSum)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Implied accumulator picks

    logic [4:0] accByteIndex;
    logic [4:0] accPairIndex;
    logic impliedKnown;

    // The accumulator follows the active bank like every other register, so an
    // interrupt handler that switches banks gets its own multiply operands;
    // the pair index names the even byte, its odd partner is the high half
    assign accByteIndex = {bankSel, OAG_REG_A};
    assign accPairIndex = {bankSel, OAG_PAIR_ACC, 1'b0};

    // Unassigned implied codes fault instead of touching the accumulator
    always_comb begin
        case (impliedOp)
            OAG_IMP_MULTIPLY, OAG_IMP_WORDDIVIDE, OAG_IMP_ADJADD,
            OAG_IMP_ADJSUB, OAG_IMP_ROTLEFT, OAG_IMP_ROTRIGHT: begin
                impliedKnown = 1'b1;
            end
            default: begin
                impliedKnown = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Short direct window

    logic shortLowImm;
    logic [15:0] shortAddr;
    logic shortOddWord;

    // bit 8 from immediate range
    // Low immediates fold up past the RAM top into the register page, so the
    // window is one contiguous span with no hole between its halves
    always_comb begin
        shortLowImm = (imm8 < OAG_SHORT_WRAP);
        shortAddr = OAG_SHORT_BASE | {8'h00, imm8};
        shortAddr[OAG_SHORT_BIT] = shortLowImm;
    end

    // even word address check
    // Only flagged here; the core decides how a misaligned word is trapped
    assign shortOddWord = wordOp & imm8[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Register page

    logic [15:0] sfrAddr;
    logic sfrInGap;
    logic sfrOddWord;

    assign sfrAddr = {OAG_SFR_PAGE, imm8};

    // even word SFR check
    // A gap address is still shown on the address output; only the fault marks it
    always_comb begin
        sfrInGap = (imm8 >= OAG_SFR_GAP_LO) && (imm8 <= OAG_SFR_GAP_HI);
        sfrOddWord = wordOp & imm8[0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pointer and stack addresses

    logic [15:0] pointerAddr;
    logic stackBelow;
    logic stackAbove;

    // banked pointer indirect
    // Both pairs already come from the active bank; the opcode bit only picks one
    assign pointerAddr = pointerIsBase ? basePointerPair : secondPointerPair;

    // stack confined to RAM
    // An outside pointer still yields its address; the fault lets the core stop
    // the push before it lands in some other memory, and a bad pop before it
    // returns data that never came from the stack
    always_comb begin
        stackBelow = (stack_pointer < STACK_LO);
        stackAbove = (stack_pointer > STACK_HI);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode check

    logic modeKnown;
    logic memResult;

    // Codes outside the mode table give no result, rather than a stray address
    // that the memory bus would act on
    always_comb begin
        case (opMode)
            OAG_MODE_IMPLIED, OAG_MODE_REG8, OAG_MODE_REG16, OAG_MODE_DIRECT,
            OAG_MODE_SHORT, OAG_MODE_SFR, OAG_MODE_INDIRECT, OAG_MODE_BASED,
            OAG_MODE_BASEDIDX, OAG_MODE_STACK: begin
                modeKnown = 1'b1;
            end
            default: begin
                modeKnown = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-value computation

    logic next_resValid;
    logic next_isRegister;
    logic [4:0] next_srcIndex;
    logic [4:0] next_dstIndex;
    logic next_dstWord;
    logic [15:0] next_effAddr;
    logic next_inShortRam;
    logic next_inShortSfr;
    logic next_addrFault;

    // Decode the mode into register picks or an address
    always_comb begin
        next_resValid = opValid && modeKnown;
        next_isRegister = 1'b0;
        next_srcIndex = 5'h00;
        next_dstIndex = 5'h00;
        next_dstWord = 1'b0;
        next_effAddr = 16'h0000;
        next_addrFault = 1'b0;
        if (opValid) begin
            case (opMode)
                OAG_MODE_IMPLIED: begin
                    next_isRegister = 1'b1;
                    case (impliedOp)
                        OAG_IMP_MULTIPLY: begin
                            next_srcIndex = accByteIndex;
                            next_dstIndex = accPairIndex;
                            next_dstWord = 1'b1;
                        end
                        OAG_IMP_WORDDIVIDE: begin
                            next_srcIndex = accPairIndex;
                            next_dstIndex = accPairIndex;
                            next_dstWord = 1'b1;
                        end
                        OAG_IMP_ADJADD, OAG_IMP_ADJSUB: begin
                            next_srcIndex = accByteIndex;
                            next_dstIndex = accByteIndex;
                        end
                        OAG_IMP_ROTLEFT, OAG_IMP_ROTRIGHT: begin
                            next_srcIndex = accByteIndex;
                            next_dstIndex = accByteIndex;
                        end
                        default: begin
                            next_isRegister = impliedKnown;
                            next_addrFault = !impliedKnown;
                        end
                    endcase
                end
                OAG_MODE_REG8, OAG_MODE_REG16: begin
                    next_isRegister = 1'b1;
                    next_srcIndex = regIndex;
                    next_dstIndex = regIndex;
                    next_dstWord = (opMode == OAG_MODE_REG16);
                end
                OAG_MODE_DIRECT: begin
                    next_effAddr = imm16;
                end
                OAG_MODE_SHORT: begin
                    next_effAddr = shortAddr;
                    next_addrFault = shortOddWord;
                end
                OAG_MODE_SFR: begin
                    next_effAddr = sfrAddr;
                    next_addrFault = sfrInGap | sfrOddWord;
                end
                OAG_MODE_INDIRECT: begin
                    next_effAddr = pointerAddr;
                end
                OAG_MODE_BASED: begin
                    next_effAddr = basedSum;
                end
                OAG_MODE_BASEDIDX: begin
                    next_effAddr = indexedSum;
                end
                OAG_MODE_STACK: begin
                    next_effAddr = stack_pointer;
                    next_addrFault = stackBelow | stackAbove;
                end
                default: begin
                    next_resValid = 1'b0;
                end
            endcase
        end
    end

    // low SFRs via short window
    // Judged on the final address, so pointer accesses that land in the window
    // are flagged the same way as short direct ones
    always_comb begin
        memResult = !next_isRegister && next_resValid;
        next_inShortRam = memResult
            && (next_effAddr >= OAG_RAM_LO) && (next_effAddr <= OAG_RAM_HI);
        next_inShortSfr = memResult
            && (next_effAddr[15:8] == OAG_SFR_PAGE) && (next_effAddr[7:0] < OAG_SHORT_WRAP);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result registers; outputs come straight from here

    // Registered results; the one clock of latency keeps the adders and compares
    // off the register file read path
    always_ff @(posedge clk) begin
        if (reset) begin
            resValid <= 1'b0;
            isRegister <= 1'b0;
            srcIndex <= 5'h00;
            dstIndex <= 5'h00;
            dstWord <= 1'b0;
            effAddr <= 16'h0000;
            inShortRam <= 1'b0;
            inShortSfr <= 1'b0;
            addrFault <= 1'b0;
        end else begin
            resValid <= next_resValid;
            isRegister <= next_isRegister;
            srcIndex <= next_srcIndex;
            dstIndex <= next_dstIndex;
            dstWord <= next_dstWord;
            effAddr <= next_effAddr;
            inShortRam <= next_inShortRam;
            inShortSfr <= next_inShortSfr;
            addrFault <= next_addrFault;
        end
    end
endmodule : oag_operand_address_generator

// ===== rtl/oag_reg_select.sv
// Purpose: Maps bank flags and register code to an absolute file index.
// Assumes: Register file holds four banks of eight bytes.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module oag_reg_select (
    input wire logic [1:0] bankSel, // Bank select flags
    input wire logic [2:0] regCode, // Register code from opcode
    input wire logic wordOp, // Code names a pair
    output logic [4:0] byteIndex, // Absolute byte index, low byte for pairs
    output logic [2:0] absReg // Absolute register number within the bank
);
    import oag_pkg::*;

    // Pairs take the even register as their low half
    always_comb begin
        absReg = wordOp ? {regCode[1:0], 1'b0} : regCode;
        byteIndex = {bankSel, absReg};
    end
endmodule : oag_reg_select

// ===== shared/oag_pkg.sv
// Purpose: Constants and types for the operand address generator.
// Assumes: 8-bit core, 16-bit address space, four register banks.
// Notes: Shared by the generator and its two helper modules.
package oag_pkg;

    // Operand addressing modes presented by the decoder
    typedef enum logic [3:0] {
        OAG_MODE_NONE     = 4'b0000,
        OAG_MODE_IMPLIED  = 4'b0001,
        OAG_MODE_REG8     = 4'b0010,
        OAG_MODE_REG16    = 4'b0011,
        OAG_MODE_DIRECT   = 4'b0100,
        OAG_MODE_SHORT    = 4'b0101,
        OAG_MODE_SFR      = 4'b0110,
        OAG_MODE_INDIRECT = 4'b0111,
        OAG_MODE_BASED    = 4'b1000,
        OAG_MODE_BASEDIDX = 4'b1001,
        OAG_MODE_STACK    = 4'b1010
    } oag_mode_e;

    // Instructions that address the accumulator without an operand field
    typedef enum logic [2:0] {
        OAG_IMP_MULTIPLY   = 3'b000,
        OAG_IMP_WORDDIVIDE = 3'b001,
        OAG_IMP_ADJADD     = 3'b010,
        OAG_IMP_ADJSUB     = 3'b011,
        OAG_IMP_ROTLEFT    = 3'b100,
        OAG_IMP_ROTRIGHT   = 3'b101
    } oag_implied_e;

    // Absolute register and pair numbers
    localparam logic [2:0] OAG_REG_X = 3'h0;
    localparam logic [2:0] OAG_REG_A = 3'h1;
    localparam logic [2:0] OAG_REG_C = 3'h2;
    localparam logic [2:0] OAG_REG_B = 3'h3;
    localparam logic [1:0] OAG_PAIR_ACC = 2'h0;
    localparam logic [1:0] OAG_PAIR_SECOND = 2'h2;
    localparam logic [1:0] OAG_PAIR_BASE = 2'h3;

    // Address map figures
    localparam logic [15:0] OAG_SHORT_BASE = 16'hFE00;
    localparam logic [7:0] OAG_SHORT_WRAP = 8'h20;
    localparam logic [7:0] OAG_SFR_PAGE = 8'hFF;
    localparam logic [7:0] OAG_SFR_GAP_LO = 8'hD0;
    localparam logic [7:0] OAG_SFR_GAP_HI = 8'hDF;
    localparam logic [15:0] OAG_RAM_LO = 16'hFE20;
    localparam logic [15:0] OAG_RAM_HI = 16'hFEFF;
    localparam logic [15:0] OAG_STACK_LO_DEF = 16'hFB00;
    localparam logic [15:0] OAG_STACK_HI_DEF = 16'hFEFF;
    localparam int OAG_SHORT_BIT = 8;

endpackage : oag_pkg

// ===== testbench/oag_props.sv
// Purpose: Port checks for the operand address generator.
// Assumes: Results land one clock after the request edge.
// Notes: Only modes with a fixed address figure are watched here.
`timescale 1ns/1ps
module oag_props #(
    parameter logic [15:0] STACK_LO = oag_pkg::OAG_STACK_LO_DEF, // Stack low bound
    parameter logic [15:0] STACK_HI = oag_pkg::OAG_STACK_HI_DEF // Stack high bound
) (
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic opValid, // Request
    input wire oag_pkg::oag_mode_e opMode, // Mode
    input wire logic [15:0] imm16, // Long immediate
    input wire logic [7:0] imm8, // Byte immediate
    input wire logic wordOp, // Word operand
    input wire logic [15:0] basePointerPair, // Base pair
    input wire logic [15:0] stack_pointer, // Stack pointer
    input wire logic resValid, // Result strobe
    input wire logic [15:0] effAddr, // Address
    input wire logic inShortRam, // RAM flag
    input wire logic inShortSfr, // SFR flag
    input wire logic addrFault // Fault flag
);
    import oag_pkg::*;
    // Every check looks at the cycle after the request edge
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_short;
        opValid && opMode == OAG_MODE_SHORT;
    endsequence
    sequence s_sfr;
        opValid && opMode == OAG_MODE_SFR;
    endsequence
    a_direct_addr: assert property (opValid && opMode == OAG_MODE_DIRECT |=>
        resValid && effAddr == $past(imm16)) else $error("direct address wrong");
    a_short_bit8: assert property (s_short |=> resValid &&
        effAddr == {7'h7F, $past(imm8) < 8'h20, $past(imm8)}) else $error("short address wrong");
    a_short_window: assert property (s_short |=>
        inShortRam == ($past(imm8) >= 8'h20) && inShortSfr == ($past(imm8) < 8'h20))
        else $error("short window flags wrong");
    a_sfr_page: assert property (s_sfr |=> effAddr == {8'hFF, $past(imm8)})
        else $error("sfr address wrong");
    a_sfr_gap: assert property (s_sfr |=> addrFault ==
        (($past(imm8) inside {[8'hD0:8'hDF]}) || ($past(wordOp) && $past(imm8[0]))))
        else $error("sfr fault flag wrong");
    a_based_sum: assert property (opValid && opMode == OAG_MODE_BASED |=>
        effAddr == 16'($past(basePointerPair) + $past(imm8))) else $error("based sum wrong");
    a_stack_addr: assert property (opValid && opMode == OAG_MODE_STACK |=>
        resValid && effAddr == $past(stack_pointer)) else $error("stack address wrong");
    a_stack_range: assert property (opValid && opMode == OAG_MODE_STACK |=>
        addrFault == ($past(stack_pointer) < STACK_LO || $past(stack_pointer) > STACK_HI))
        else $error("stack range flag wrong");
endmodule : oag_props
////////////////////////////////////////
bind oag_operand_address_generator oag_props #(.STACK_LO(STACK_LO), .STACK_HI(STACK_HI))
    oag_props_inst (.clk(clk), .reset(reset), .opValid(opValid), .opMode(opMode),
    .imm16(imm16), .imm8(imm8), .wordOp(wordOp), .basePointerPair(basePointerPair),
    .stack_pointer(stack_pointer), .resValid(resValid), .effAddr(effAddr),
    .inShortRam(inShortRam), .inShortSfr(inShortSfr), .addrFault(addrFault));

// ===== testbench/operand_address_generator_tb.sv
// Purpose: Self-checking bench for the operand address generator.
// Assumes: One request every second cycle, answer one cycle later.
// Notes: Default stack bounds are kept.
`timescale 1ns/1ps
module operand_address_generator_tb;
    import oag_pkg::*;
    logic clk = 0, reset = 1, opValid = 0, wordOp = 0, indexUsesB = 0, pointerIsBase = 0;
    logic bank_select_bit0 = 0, bank_select_bit1 = 0;
    oag_mode_e opMode = OAG_MODE_NONE;
    oag_implied_e impliedOp = OAG_IMP_MULTIPLY;
    logic [2:0] regCode = 3'h0;
    logic [7:0] imm8 = 8'h00, indexB = 8'h20, indexC = 8'h0F;
    logic [15:0] imm16 = 16'h0000, basePointerPair = 16'hFFF0, secondPointerPair = 16'h1357;
    logic [15:0] stack_pointer = 16'hFB00, effAddr;
    logic resValid, isRegister, dstWord, inShortRam, inShortSfr, addrFault;
    logic [4:0] srcIndex, dstIndex;
    int num_errors = 0, compares = 0;
    oag_operand_address_generator oag_operand_address_generator_inst (.clk(clk),
        .reset(reset), .opValid(opValid), .opMode(opMode), .impliedOp(impliedOp),
        .regCode(regCode), .wordOp(wordOp), .indexUsesB(indexUsesB),
        .pointerIsBase(pointerIsBase), .imm16(imm16), .imm8(imm8),
        .bank_select_bit0(bank_select_bit0), .bank_select_bit1(bank_select_bit1),
        .basePointerPair(basePointerPair), .secondPointerPair(secondPointerPair),
        .indexB(indexB), .indexC(indexC), .stack_pointer(stack_pointer),
        .resValid(resValid), .isRegister(isRegister), .srcIndex(srcIndex),
        .dstIndex(dstIndex), .dstWord(dstWord), .effAddr(effAddr),
        .inShortRam(inShortRam), .inShortSfr(inShortSfr), .addrFault(addrFault));
    // Free-running core clock
    initial begin
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t address %h expected %h", $time, got, exp);
        end
    endtask : chk_addr
    task automatic chk_idx(input logic [4:0] got, input logic [4:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t index %h expected %h", $time, got, exp);
        end
    endtask : chk_idx
    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag
    // Called just after an edge; the result is read once it has settled
    task automatic go(input oag_mode_e m);
        opValid <= 1'b1;
        opMode <= m;
        @(posedge clk);
        opValid <= 1'b0;
        #1;
        chk_flag(resValid, 1'b1);
    endtask : go
    task automatic t_implied;
        oag_implied_e k[4] = '{OAG_IMP_ADJADD, OAG_IMP_ADJSUB, OAG_IMP_ROTLEFT, OAG_IMP_ROTRIGHT};
        @(posedge clk);
        bank_select_bit1 <= 1'b1;
        go(OAG_MODE_IMPLIED);
        chk_idx(srcIndex, 5'h11);
        chk_idx(dstIndex, 5'h10);
        chk_flag(dstWord, 1'b1);
        @(posedge clk);
        impliedOp <= OAG_IMP_WORDDIVIDE;
        go(OAG_MODE_IMPLIED);
        chk_idx(srcIndex, 5'h10);
        chk_idx(dstIndex, 5'h10);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            impliedOp <= k[i];
            go(OAG_MODE_IMPLIED);
            chk_idx(dstIndex, 5'h11);
        end
        $display("implied test done");
    endtask : t_implied
    task automatic t_register;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            bank_select_bit1 <= 1'b0;
            bank_select_bit0 <= 1'b1;
            regCode <= 3'(i);
            go(OAG_MODE_REG8);
            chk_flag(isRegister, 1'b1);
            chk_idx(srcIndex, {2'b01, 3'(i)});
        end
        @(posedge clk);
        wordOp <= 1'b1;
        go(OAG_MODE_REG16);
        chk_idx(srcIndex, 5'h0E);
        chk_flag(dstWord, 1'b1);
        $display("register test done");
    endtask : t_register
    task automatic t_direct_short;
        logic [7:0] v[4] = '{8'h00, 8'h1F, 8'h20, 8'hFF};
        @(posedge clk);
        wordOp <= 1'b0;
        imm16 <= 16'hFE00;
        go(OAG_MODE_DIRECT);
        chk_addr(effAddr, 16'hFE00);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            imm8 <= v[i];
            go(OAG_MODE_SHORT);
            chk_addr(effAddr, {7'h7F, v[i] < 8'h20, v[i]});
            chk_flag(inShortRam, v[i] >= 8'h20);
            chk_flag(inShortSfr, v[i] < 8'h20);
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            wordOp <= 1'b1;
            imm8 <= 8'h21 + 8'(i);
            go(OAG_MODE_SHORT);
            chk_flag(addrFault, i == 0);
        end
        $display("direct and short test done");
    endtask : t_direct_short
    task automatic t_sfr;
        logic [7:0] v[5] = '{8'h20, 8'hCF, 8'hD0, 8'hDF, 8'hE0};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            wordOp <= 1'b0;
            imm8 <= v[i];
            go(OAG_MODE_SFR);
            chk_addr(effAddr, {8'hFF, v[i]});
            chk_flag(addrFault, v[i] inside {[8'hD0:8'hDF]});
        end
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            wordOp <= 1'b1;
            imm8 <= 8'hE1 - 8'(i);
            go(OAG_MODE_SFR);
            chk_flag(addrFault, i == 0);
        end
        $display("sfr test done");
    endtask : t_sfr
    task automatic t_pointer;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            pointerIsBase <= 1'(i);
            indexUsesB <= 1'(i);
            imm8 <= 8'h30;
            go(OAG_MODE_INDIRECT);
            chk_addr(effAddr, i ? 16'hFFF0 : 16'h1357);
            @(posedge clk);
            go(OAG_MODE_BASEDIDX);
            chk_addr(effAddr, i ? 16'h0010 : 16'hFFFF);
        end
        @(posedge clk);
        go(OAG_MODE_BASED);
        chk_addr(effAddr, 16'h0020);
        $display("pointer test done");
    endtask : t_pointer
    task automatic t_stack;
        logic [15:0] v[4] = '{16'hFB00, 16'hFEFE, 16'hFAFF, 16'hFF00};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            stack_pointer <= v[i];
            go(OAG_MODE_STACK);
            chk_addr(effAddr, v[i]);
            chk_flag(addrFault, i > 1);
        end
        $display("stack test done");
    endtask : t_stack
    ////////////////////////////////////////
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // Watchdog: the tests need well under two hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    // Main sequence after five cycles of reset
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk_flag(resValid, 1'b0);
        t_implied();
        t_register();
        t_direct_short();
        t_sfr();
        t_pointer();
        t_stack();
        report_and_stop();
    end
endmodule : operand_address_generator_tb
